// ---- psup_pkg.sv ----
`default_nettype none
package psup_pkg;
    localparam int CNT_W = 13;
    localparam int CE_W = 12;
    localparam int PRESC_W = 18;
    localparam int SYNC_W = 3;

    localparam int CLK_PERIOD_NS = 4;
    localparam int NS_PER_US = 1000;
    localparam int NS_PER_MS = 1000000;
    localparam int MS_CYCLES_DEF = NS_PER_MS / CLK_PERIOD_NS;

    localparam logic [CNT_W-1:0] WD_SLOW_MS = 13'h0640;
    localparam logic [CNT_W-1:0] WD_FAST_MS = 13'h0064;
    localparam logic [CNT_W-1:0] RST_MS = 13'h00c8;

    localparam logic [CNT_W-1:0] EXT_WD_NORM_CLKS = 13'h0400;
    localparam logic [CNT_W-1:0] EXT_WD_AFTER_CLKS = 13'h1000;
    localparam logic [CNT_W-1:0] EXT_RST_CLKS = 13'h0800;

    localparam int CE_HOLD_US = 15;
    localparam int CE_HOLD_CYC_INT = CE_HOLD_US * NS_PER_US / CLK_PERIOD_NS;
    localparam logic [CE_W-1:0] CE_HOLD_LAST = CE_W'(CE_HOLD_CYC_INT - 1);

    localparam int SB_LOW = 0;
    localparam int SB_BHI = 1;
    localparam int SB_PF = 2;
    localparam logic [SYNC_W-1:0] SYNC_RST = 3'h1;

    typedef enum logic [0:0] {
        ST_RESET = 1'b0,
        ST_RUN = 1'b1
    } psup_state_t;
endpackage
`default_nettype wire

// ---- psup_sync.sv ----
`default_nettype none
module psup_sync
    import psup_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [SYNC_W-1:0] d,
    output logic [SYNC_W-1:0] q
);
    typedef struct packed {
        logic [SYNC_W-1:0] meta;
        logic [SYNC_W-1:0] sync;
    } psup_sync_t;

    psup_sync_t r_ff;
    psup_sync_t nxt_r;

    // The first stage feeds only the second stage.
    always_comb begin
        nxt_r = r_ff;
        nxt_r.meta = d;
        nxt_r.sync = r_ff.meta;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_ff.meta <= SYNC_RST;
            r_ff.sync <= SYNC_RST;
        end else if (clk_en) begin
            r_ff <= nxt_r;
        end
    end

    assign q = r_ff.sync;

    a_sync_two_stage: assert property (@(posedge clk) disable iff (!nrst)
        clk_en ##1 clk_en |=> q == $past(d, 2))
        else $error("synchroniser output does not follow input after two stages");
endmodule
`default_nettype wire

// ---- psup_top.sv ----
`default_nettype none
module psup_top
    import psup_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic CLK_EN,
    input wire logic SUPPLY_LOW_IN,
    input wire logic BACKUP_HIGHER_IN,
    input wire logic POWERFAIL_SENSE_IN,
    input wire logic TIMING_SOURCE_SEL,
    input wire logic TIMING_A,
    input wire logic WATCHDOG_KICK_IN,
    input wire logic WATCHDOG_KICK_MID,
    input wire logic CHIP_SELECT_N_IN,
    output logic BACKUP_ACTIVE_OUT,
    output logic SUPPLY_LOW_N,
    output logic RESET_N,
    output logic RESET_HI_OUT,
    output logic RESET_HI_OE,
    output logic POWERFAIL_FLAG_N,
    output logic WATCHDOG_FAULT_N,
    output logic CHIP_SELECT_N_OUT
);
    typedef struct packed {
        psup_state_t state;
        logic reset_n;
        logic [CNT_W-1:0] rst_cnt;
        logic [CNT_W-1:0] wd_cnt;
        logic after_rst;
        logic kick_prev;
        logic fault_n;
        logic ce_pass;
        logic ce_hold;
        logic [CE_W-1:0] ce_cnt;
        logic [PRESC_W-1:0] presc;
        logic osc_prev;
        logic backup;
        logic low_n;
        logic pf_n;
    } psup_top_t;

    psup_top_t r_ff;
    psup_top_t nxt_r;
    logic [SYNC_W-1:0] cmp_s;
    logic low;
    logic ext;
    logic fast;
    logic tick;
    logic kick_edge;

    function automatic logic [CNT_W-1:0] wd_limit(input logic is_ext, input logic is_fast, input logic after);
        logic [CNT_W-1:0] lim;
        lim = WD_SLOW_MS;
        if (is_ext) begin
            lim = after ? EXT_WD_AFTER_CLKS : EXT_WD_NORM_CLKS;
        end else if (is_fast && !after) begin
            lim = WD_FAST_MS;
        end
        return lim;
    endfunction

    function automatic logic [CNT_W-1:0] rst_limit(input logic is_ext);
        return is_ext ? EXT_RST_CLKS : RST_MS;
    endfunction

    psup_sync u_sync (
        .clk(REF_CLK),
        .nrst(NRST),
        .clk_en(CLK_EN),
        .d({POWERFAIL_SENSE_IN, BACKUP_HIGHER_IN, SUPPLY_LOW_IN}),
        .q(cmp_s)
    );

    assign low = cmp_s[SB_LOW];
    assign ext = !TIMING_SOURCE_SEL;
    assign fast = TIMING_SOURCE_SEL && !TIMING_A;
    assign kick_edge = !WATCHDOG_KICK_MID && (WATCHDOG_KICK_IN != r_ff.kick_prev);

    always_comb begin
        nxt_r = r_ff;
        tick = 1'b0;
        nxt_r.osc_prev = TIMING_A;
        nxt_r.kick_prev = WATCHDOG_KICK_IN;

        // In external mode each rising edge on timing_a is one count.
        if (ext) begin
            tick = TIMING_A && !r_ff.osc_prev;
            nxt_r.presc = '0;
        end else if (r_ff.presc == PRESC_W'(MS_CYCLES - 1)) begin
            tick = 1'b1;
            nxt_r.presc = '0;
        end else begin
            nxt_r.presc = r_ff.presc + 1'b1;
        end

        if (low && cmp_s[SB_BHI]) begin
            nxt_r.backup = 1'b1;
        end else if (!low && !cmp_s[SB_BHI]) begin
            nxt_r.backup = 1'b0;
        end

        nxt_r.low_n = !low;
        nxt_r.pf_n = cmp_s[SB_PF];

        // Supply low, an open kick input or a kick edge all release the fault.
        if (low || WATCHDOG_KICK_MID || kick_edge) begin
            nxt_r.fault_n = 1'b1;
        end

        case (r_ff.state)
            ST_RESET: begin
                nxt_r.wd_cnt = '0;
                if (low) begin
                    nxt_r.rst_cnt = '0;
                end else if (tick) begin
                    if (r_ff.rst_cnt == rst_limit(ext) - 1'b1) begin
                        nxt_r.state = ST_RUN;
                        nxt_r.reset_n = 1'b1;
                        nxt_r.rst_cnt = '0;
                        nxt_r.after_rst = 1'b1;
                    end else begin
                        nxt_r.rst_cnt = r_ff.rst_cnt + 1'b1;
                    end
                end
            end
            ST_RUN: begin
                if (low) begin
                    nxt_r.state = ST_RESET;
                    nxt_r.reset_n = 1'b0;
                    nxt_r.rst_cnt = '0;
                end else if (WATCHDOG_KICK_MID || kick_edge) begin
                    nxt_r.wd_cnt = '0;
                    if (kick_edge) begin
                        nxt_r.after_rst = 1'b0;
                    end
                end else if (tick) begin
                    if (r_ff.wd_cnt == wd_limit(ext, fast, r_ff.after_rst) - 1'b1) begin
                        nxt_r.fault_n = 1'b0;
                        nxt_r.state = ST_RESET;
                        nxt_r.reset_n = 1'b0;
                        nxt_r.rst_cnt = '0;
                        nxt_r.wd_cnt = '0;
                    end else begin
                        nxt_r.wd_cnt = r_ff.wd_cnt + 1'b1;
                    end
                end
            end
            default: begin
                nxt_r.state = ST_RESET;
                nxt_r.reset_n = 1'b0;
            end
        endcase

        // A cycle already under way when reset asserts may finish for a bounded time.
        if (nxt_r.state == ST_RUN) begin
            nxt_r.ce_hold = 1'b0;
        end else if (r_ff.state == ST_RUN) begin
            nxt_r.ce_hold = !CHIP_SELECT_N_IN;
            nxt_r.ce_cnt = '0;
        end else if (r_ff.ce_hold) begin
            if (CHIP_SELECT_N_IN || r_ff.ce_cnt == CE_HOLD_LAST) begin
                nxt_r.ce_hold = 1'b0;
            end else begin
                nxt_r.ce_cnt = r_ff.ce_cnt + 1'b1;
            end
        end
        nxt_r.ce_pass = (nxt_r.state == ST_RUN) || nxt_r.ce_hold;
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            r_ff.state <= ST_RESET;
            r_ff.reset_n <= 1'b0;
            r_ff.rst_cnt <= '0;
            r_ff.wd_cnt <= '0;
            r_ff.after_rst <= 1'b0;
            r_ff.kick_prev <= 1'b0;
            r_ff.fault_n <= 1'b1;
            r_ff.ce_pass <= 1'b0;
            r_ff.ce_hold <= 1'b0;
            r_ff.ce_cnt <= '0;
            r_ff.presc <= '0;
            r_ff.osc_prev <= 1'b0;
            r_ff.backup <= 1'b0;
            r_ff.low_n <= 1'b0;
            r_ff.pf_n <= 1'b0;
        end else if (CLK_EN) begin
            r_ff <= nxt_r;
        end
    end

    assign BACKUP_ACTIVE_OUT = r_ff.backup;
    assign SUPPLY_LOW_N = r_ff.low_n;
    assign RESET_N = r_ff.reset_n;
    // The open-drain pin pulls low only while reset is inactive.
    assign RESET_HI_OUT = 1'b0;
    assign RESET_HI_OE = r_ff.reset_n;
    assign POWERFAIL_FLAG_N = r_ff.pf_n;
    assign WATCHDOG_FAULT_N = r_ff.fault_n;
    // The gate stays combinational so that chip-select edges pass without a clock of delay.
    assign CHIP_SELECT_N_OUT = CHIP_SELECT_N_IN || !r_ff.ce_pass;

    sequence kick_quiet;
        CLK_EN && !WATCHDOG_KICK_MID && !low && (WATCHDOG_KICK_IN == r_ff.kick_prev);
    endsequence

    sequence kick_toggle;
        CLK_EN && kick_edge;
    endsequence

    property fault_holds;
        @(posedge REF_CLK) disable iff (!NRST)
        (!WATCHDOG_FAULT_N ##0 kick_quiet) |=> !WATCHDOG_FAULT_N;
    endproperty

    property fault_clears;
        @(posedge REF_CLK) disable iff (!NRST)
        (!WATCHDOG_FAULT_N ##0 kick_toggle) |=> WATCHDOG_FAULT_N;
    endproperty

    a_backup_select: assert property (@(posedge REF_CLK) disable iff (!NRST)
        CLK_EN && low && cmp_s[SB_BHI] |=> BACKUP_ACTIVE_OUT)
        else $error("backup not selected with supply low and backup higher");
    a_main_select: assert property (@(posedge REF_CLK) disable iff (!NRST)
        CLK_EN && !low && !cmp_s[SB_BHI] |=> !BACKUP_ACTIVE_OUT)
        else $error("main supply not selected when good");
    a_lowline_follow: assert property (@(posedge REF_CLK) disable iff (!NRST)
        CLK_EN |=> SUPPLY_LOW_N == !$past(low))
        else $error("supply-low output lags the comparison");
    a_reset_on_low: assert property (@(posedge REF_CLK) disable iff (!NRST)
        CLK_EN && low |=> !RESET_N && (CHIP_SELECT_N_OUT || !CHIP_SELECT_N_IN))
        else $error("reset not asserted while supply low");
    a_reset_inverse: assert property (@(posedge REF_CLK) disable iff (!NRST)
        RESET_HI_OE == RESET_N && !RESET_HI_OUT)
        else $error("open-drain reset not the inverse of reset");
    a_fault_mid: assert property (@(posedge REF_CLK) disable iff (!NRST)
        CLK_EN && WATCHDOG_KICK_MID |=> WATCHDOG_FAULT_N)
        else $error("fault output low while kick is open");
    a_fault_reset: assert property (@(posedge REF_CLK) disable iff (!NRST)
        $fell(WATCHDOG_FAULT_N) |-> !RESET_N && $past(r_ff.state) == ST_RUN)
        else $error("fault without reset from run state");
    a_fault_hold: assert property (fault_holds)
        else $error("fault output released without a kick transition");
    a_fault_clear: assert property (fault_clears)
        else $error("fault output not released on kick transition");
    a_ce_gate: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !CHIP_SELECT_N_OUT |-> !CHIP_SELECT_N_IN && (RESET_N || r_ff.ce_hold))
        else $error("chip-select passed while blocked");
    a_ce_hold_bound: assert property (@(posedge REF_CLK) disable iff (!NRST)
        r_ff.ce_hold |-> r_ff.ce_cnt <= CE_HOLD_LAST && r_ff.state == ST_RESET)
        else $error("chip-select hold exceeds its window");
    a_powerfail_flag: assert property (@(posedge REF_CLK) disable iff (!NRST)
        CLK_EN |=> POWERFAIL_FLAG_N == $past(cmp_s[SB_PF]))
        else $error("power-fail flag does not follow sense");
    a_wd_limit: assert property (@(posedge REF_CLK) disable iff (!NRST)
        r_ff.state == ST_RUN && CLK_EN && tick && !kick_edge && !WATCHDOG_KICK_MID && !low
        && r_ff.wd_cnt == wd_limit(ext, fast, r_ff.after_rst) - 1'b1 |=> !WATCHDOG_FAULT_N && !RESET_N)
        else $error("watchdog did not fire at its limit");
    a_rst_release: assert property (@(posedge REF_CLK) disable iff (!NRST)
        $rose(RESET_N) |-> $past(r_ff.rst_cnt) == rst_limit($past(ext)) - 1'b1)
        else $error("reset released before its timeout");

    sequence reset_entry;
        $fell(RESET_N);
    endsequence

    a_ce_hold_start: assert property (@(posedge REF_CLK) disable iff (!NRST)
        reset_entry ##0 !$past(CHIP_SELECT_N_IN) |-> r_ff.ce_pass)
        else $error("chip-select cut at once although a cycle was under way");
    a_ce_block_idle: assert property (@(posedge REF_CLK) disable iff (!NRST)
        reset_entry ##0 $past(CHIP_SELECT_N_IN) |-> CHIP_SELECT_N_OUT)
        else $error("chip-select passed after reset with no cycle under way");
    a_ce_release: assert property (@(posedge REF_CLK) disable iff (!NRST)
        CLK_EN && r_ff.ce_hold && CHIP_SELECT_N_IN |=> !r_ff.ce_hold)
        else $error("chip-select hold not ended when the input rose");
    a_backup_keep: assert property (@(posedge REF_CLK) disable iff (!NRST)
        CLK_EN && (low != cmp_s[SB_BHI]) |=> $stable(BACKUP_ACTIVE_OUT))
        else $error("supply source changed without both conditions");
    a_fault_supply: assert property (@(posedge REF_CLK) disable iff (!NRST)
        CLK_EN && low |=> WATCHDOG_FAULT_N)
        else $error("fault output low while supply is low");
endmodule
`default_nettype wire

// ---- psup_host.sv ----
`default_nettype none
module psup_host (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic float_in,
    output logic kick,
    output logic kick_mid
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt;
    // An open kick line sits at mid level, so the level seen behind it is noise.
    assign kick_mid = float_in;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
            kick <= 1'b0;
        end else begin
            cnt <= run ? cnt + 4'h1 : 4'h0;
            if (float_in || (run && cnt == 4'hf)) begin
                kick <= ~kick;
            end
        end
    end
endmodule
`default_nettype wire

// ---- test_processor_supervisor.sv ----
`default_nettype none
module test_processor_supervisor
    import psup_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int MS = 4;
    logic REF_CLK = 1'b0;
    logic NRST = 1'b0;
    logic CLK_EN = 1'b1;
    logic SUPPLY_LOW_IN = 1'b0;
    logic BACKUP_HIGHER_IN = 1'b0;
    logic POWERFAIL_SENSE_IN = 1'b1;
    logic TIMING_SOURCE_SEL = 1'b1;
    logic TIMING_A = 1'b0;
    logic CHIP_SELECT_N_IN = 1'b1;
    logic WATCHDOG_KICK_IN, WATCHDOG_KICK_MID, BACKUP_ACTIVE_OUT, SUPPLY_LOW_N, RESET_N;
    logic RESET_HI_OUT, RESET_HI_OE, POWERFAIL_FLAG_N, WATCHDOG_FAULT_N, CHIP_SELECT_N_OUT;
    logic run = 1'b0;
    logic flt = 1'b1;
    logic ext = 1'b0;
    logic ta_lvl = 1'b0;
    logic bexp = 1'b0;
    logic [1:0] ta_div = 2'h0;
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 84;
    int n, cyc, c0;

    psup_top #(.MS_CYCLES(MS)) dut (.REF_CLK(REF_CLK), .NRST(NRST), .CLK_EN(CLK_EN),
        .SUPPLY_LOW_IN(SUPPLY_LOW_IN), .BACKUP_HIGHER_IN(BACKUP_HIGHER_IN),
        .POWERFAIL_SENSE_IN(POWERFAIL_SENSE_IN), .TIMING_SOURCE_SEL(TIMING_SOURCE_SEL),
        .TIMING_A(TIMING_A), .WATCHDOG_KICK_IN(WATCHDOG_KICK_IN), .WATCHDOG_KICK_MID(WATCHDOG_KICK_MID),
        .CHIP_SELECT_N_IN(CHIP_SELECT_N_IN), .BACKUP_ACTIVE_OUT(BACKUP_ACTIVE_OUT),
        .SUPPLY_LOW_N(SUPPLY_LOW_N), .RESET_N(RESET_N), .RESET_HI_OUT(RESET_HI_OUT),
        .RESET_HI_OE(RESET_HI_OE), .POWERFAIL_FLAG_N(POWERFAIL_FLAG_N),
        .WATCHDOG_FAULT_N(WATCHDOG_FAULT_N), .CHIP_SELECT_N_OUT(CHIP_SELECT_N_OUT));
    psup_host host (.clk(REF_CLK), .nrst(NRST), .run(run), .float_in(flt),
        .kick(WATCHDOG_KICK_IN), .kick_mid(WATCHDOG_KICK_MID));

    always #2 REF_CLK = ~REF_CLK;
    // The external timing clock has a period of four reference cycles.
    always @(posedge REF_CLK) begin
        cyc++;
        #1;
        ta_div = ta_div + 2'h1;
        TIMING_A = ext ? ta_div[1] : ta_lvl;
    end
    always @(negedge REF_CLK) begin
        if (NRST) begin
            chk_bit(RESET_HI_OE, RESET_N);
            chk_bit(RESET_HI_OUT, 1'b0);
        end
    end

    task automatic stop_test();
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge REF_CLK);
        #1;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return RESET_N;
            1: return WATCHDOG_FAULT_N;
            default: return CHIP_SELECT_N_OUT;
        endcase
    endfunction
    // Returns the wait in n, or -1 when an optional event never came.
    task automatic wait_for(input int w, input logic v, input int bound, input bit must);
        n = 0;
        while (pick(w) !== v && n < bound) begin
            step(1);
            n++;
        end
        if (pick(w) !== v) begin
            n = -1;
            if (must) begin
                num_errors++;
                $display("mismatch t=%0t got=%h exp=%h", $time, ~v, v);
                stop_test();
            end
        end
    endtask
    task automatic kick1();
        run = 1'b1;
        step(16);
        run = 1'b0;
    endtask
    task automatic trip(input int lo, input int hi);
        wait_for(1, 1'b0, hi + 40, 1);
        c0 = cyc;
        chk_rng(n, lo, hi);
        chk_bit(RESET_N, 1'b0);
    endtask
    task automatic recover(input int lo, input int hi);
        chk_bit(WATCHDOG_FAULT_N, 1'b0);
        kick1();
        step(2);
        chk_bit(WATCHDOG_FAULT_N, 1'b1);
        wait_for(0, 1'b1, 9000, 1);
        chk_rng(cyc - c0, lo, hi);
    endtask

    initial begin
        repeat (8) @(posedge REF_CLK);
        #1 NRST = 1'b1;
        wait_for(0, 1'b1, 260 * MS, 1);
        chk_rng(n, 197 * MS, 202 * MS + 8);
        repeat (24) begin
            SUPPLY_LOW_IN = 1'($random(seed));
            BACKUP_HIGHER_IN = 1'($random(seed));
            POWERFAIL_SENSE_IN = 1'($random(seed));
            if (SUPPLY_LOW_IN && BACKUP_HIGHER_IN) begin
                bexp = 1'b1;
            end else if (!SUPPLY_LOW_IN && !BACKUP_HIGHER_IN) begin
                bexp = 1'b0;
            end
            step(4);
            chk_bit(SUPPLY_LOW_N, ~SUPPLY_LOW_IN);
            chk_bit(POWERFAIL_FLAG_N, POWERFAIL_SENSE_IN);
            chk_bit(BACKUP_ACTIVE_OUT, bexp);
            chk_bit(CHIP_SELECT_N_OUT, 1'b1);
            if (SUPPLY_LOW_IN) begin
                chk_bit(RESET_N, 1'b0);
            end
        end
        // A further supply dip with the power-fail sense held low.
        SUPPLY_LOW_IN = 1'b1;
        POWERFAIL_SENSE_IN = 1'b0;
        step(4);
        SUPPLY_LOW_IN = 1'b0;
        BACKUP_HIGHER_IN = 1'b0;
        wait_for(0, 1'b1, 260 * MS, 1);
        chk_rng(n, 197 * MS, 202 * MS + 8);
        wait_for(1, 1'b0, 1700 * MS, 0);
        chk_rng(n, -1, -1);
        CHIP_SELECT_N_IN = 1'b0;
        step(1);
        chk_bit(CHIP_SELECT_N_OUT, 1'b0);
        CHIP_SELECT_N_IN = 1'b1;
        flt = 1'b0;
        run = 1'b1;
        wait_for(1, 1'b0, 1700 * MS, 0);
        chk_rng(n, -1, -1);
        run = 1'b0;
        step(1);
        kick1();
        trip(98 * MS, 102 * MS + 4);
        recover(198 * MS, 202 * MS + 8);
        trip(1598 * MS, 1602 * MS + 4);
        recover(198 * MS, 202 * MS + 8);
        ta_lvl = 1'b1;
        kick1();
        CHIP_SELECT_N_IN = 1'b0;
        trip(1598 * MS, 1602 * MS + 4);
        step(8);
        chk_bit(CHIP_SELECT_N_OUT, 1'b0);
        // Raising the input ends the hold, so a later low stays blocked.
        CHIP_SELECT_N_IN = 1'b1;
        step(1);
        CHIP_SELECT_N_IN = 1'b0;
        step(1);
        chk_bit(CHIP_SELECT_N_OUT, 1'b1);
        CHIP_SELECT_N_IN = 1'b1;
        recover(198 * MS, 202 * MS + 8);
        ext = 1'b1;
        TIMING_SOURCE_SEL = 1'b0;
        kick1();
        CHIP_SELECT_N_IN = 1'b0;
        trip(1022 * 4, 1026 * 4);
        chk_bit(CHIP_SELECT_N_OUT, 1'b0);
        wait_for(2, 1'b1, 4000, 1);
        chk_rng(n, 3740, 3760);
        CHIP_SELECT_N_IN = 1'b1;
        recover(2046 * 4, 2050 * 4 + 8);
        // With the clock enable low a supply dip must not reach any state.
        CLK_EN = 1'b0;
        SUPPLY_LOW_IN = 1'b1;
        step(8);
        chk_bit(SUPPLY_LOW_N, 1'b1);
        chk_bit(RESET_N, 1'b1);
        SUPPLY_LOW_IN = 1'b0;
        CLK_EN = 1'b1;
        stop_test();
    end
endmodule
`default_nettype wire
